// ==== common/pcls_pkg.sv ====
/*
 * Constants and ratio function shared by both load ends.
 * Assumes a 100 MHz clk_sys at each end.
 */
package pcls_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DW     = 16;
    localparam int CNT_W  = 18;
    localparam int WCNT_W = 24;

    // ****************************************************************
    // Clock and link times
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 10000;
    localparam int T_CF2CD_NS    = 600;
    localparam int T_CF2ST0_NS   = 600;
    localparam int T_CFG_US      = 2;
    localparam int T_STATUS_MIN_US = 268;
    localparam int T_STATUS_MAX_US = 1506;
    localparam int T_CF2ST1_US   = 1506;
    localparam int T_CF2CK_US    = 1506;
    localparam int T_ST2CK_US    = 2;
    localparam int F_MAX_MHZ     = 125;
    localparam int DUTY_MIN_PCT  = 45;
    localparam int T_CD2UM_MIN_US = 175;
    localparam int T_CD2UM_MAX_US = 437;
    localparam int CD2CU_PERIODS = 4;
    localparam int T_INIT_CYCLES = 8576;

    // ****************************************************************
    // Cycle counts; minima round up
    // ****************************************************************
    localparam int T_CLK_MIN_PS    = 1000000 / F_MAX_MHZ;
    localparam int CF2CD_CYC       = T_CF2CD_NS * 1000 / CLK_PERIOD_PS;
    localparam int CF2ST0_CYC      = T_CF2ST0_NS * 1000 / CLK_PERIOD_PS;
    localparam int CFG_CYC         = (T_CFG_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STATUS_MIN_CYC_DEF = (T_STATUS_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STATUS_MAX_CYC  = T_STATUS_MAX_US * 1000000 / CLK_PERIOD_PS;
    localparam int CF2ST1_CYC      = T_CF2ST1_US * 1000000 / CLK_PERIOD_PS;
    localparam int CF2CK_CYC_DEF   = (T_CF2CK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ST2CK_CYC       = (T_ST2CK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CD2UM_MIN_CYC_DEF = (T_CD2UM_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CD2UM_MAX_CYC   = T_CD2UM_MAX_US * 1000000 / CLK_PERIOD_PS;
    localparam int CD2CU_CYC       = (CD2CU_PERIODS * T_CLK_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LCLK_HALF_MIN_CYC =
        (DUTY_MIN_PCT * T_CLK_MIN_PS + 100 * CLK_PERIOD_PS - 1) / (100 * CLK_PERIOD_PS);

    // Load clock edges per data word
    function automatic logic [2:0] pcls_ratio(input logic bus16, input logic compress, input logic encrypt);
        if (compress)
            pcls_ratio = bus16 ? 3'h4 : 3'h2;
        else if (encrypt && bus16)
            pcls_ratio = 3'h2;
        else
            pcls_ratio = 3'h1;
    endfunction : pcls_ratio

endpackage : pcls_pkg

// ==== common/pcls_link_if.sv ====
/*
 * Link between the load host and the device being loaded.
 * Assumes any outside party pulls ready/error low via ext_ready_hold.
 */
interface pcls_link_if;
    import pcls_pkg::*;

    logic          config_request_n;
    logic          dev_ready_o;
    logic          dev_ready_oe;
    logic          ext_ready_hold;
    logic          config_ready_n;
    logic          load_complete;
    logic          load_clock;
    logic [DW-1:0] data;

    // Wired low by any enabled driver, pulled up otherwise
    assign config_ready_n = !((dev_ready_oe && !dev_ready_o) || ext_ready_hold);

    modport dev (
        input  config_request_n,
        input  config_ready_n,
        input  load_clock,
        input  data,
        output dev_ready_o,
        output dev_ready_oe,
        output load_complete
    );

    modport host (
        output config_request_n,
        output load_clock,
        output data,
        input  config_ready_n,
        input  load_complete
    );

endinterface : pcls_link_if

// ==== verilog/pcls_device.sv ====
/*
 * Device end of the load: answers the request,
 * drives ready/error, latches words,
 * flags completion, counts initialization.
 * Assumes link pins come from outside the clk_sys domain.
 */
// Contract
// - Request low pulls load complete low fast
// - Request low pulls ready low fast
// - Host holds request low 2 us
// - Ready stays low 268 to 1506 us
// - Ready released within 1506 us after request
// - Unmonitoring host waits 1506 us first edge
// - Monitoring host waits 2 us after ready
// - Load clock at most 125 MHz, 45% phases
// - Words latched on load clock rising edges
// - Host holds word across N-1 further periods
// - Ratio one only without compression, encryption; code also gives one for 8-bit encryption
// - Oscillator init enters user mode 175-437 us
// - User clock enabled four periods after complete
// - Initialization takes at least 8576 clock cycles
// - Ratio per width, compression and encryption
// - Clock stops only r-1 edges after last
module pcls_device
    import pcls_pkg::*;
#(
    parameter int unsigned STATUS_MIN_CYC = STATUS_MIN_CYC_DEF,
    parameter int unsigned INIT_OSC_CYC   = CD2UM_MIN_CYC_DEF,
    parameter int unsigned INIT_USER_CYC  = T_INIT_CYCLES
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // Link to the host
    pcls_link_if.dev               link,
    // Load options
    input  wire logic              bus16,
    input  wire logic              compress,
    input  wire logic              encrypt,
    input  wire logic              use_user_clk,
    input  wire logic [WCNT_W-1:0] total_words,
    // User initialization clock pin
    input  wire logic              user_init_clock,
    // Loaded words and progress
    output logic                   word_valid,
    output logic [DW-1:0]          word_data,
    output logic                   user_clk_en,
    output logic                   user_mode
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    if (STATUS_MIN_CYC < 1 || STATUS_MIN_CYC >= (1 << CNT_W)) begin : g_bad_status
        $error("STATUS_MIN_CYC out of range");
    end
    if (INIT_OSC_CYC < 1 || INIT_OSC_CYC >= (1 << CNT_W)) begin : g_bad_osc
        $error("INIT_OSC_CYC out of range");
    end
    if (INIT_USER_CYC < 1 || INIT_USER_CYC >= (1 << CNT_W)) begin : g_bad_user
        $error("INIT_USER_CYC out of range");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [2:0] {
        S_HOLD,
        S_RELEASE,
        S_LOAD,
        S_CU_WAIT,
        S_INIT_USER,
        S_INIT_OSC,
        S_USER
    } pcls_dev_st_t;

    typedef struct packed {
        pcls_dev_st_t     st;
        logic [2:0]       rq_s;
        logic [2:0]       rd_s;
        logic [2:0]       lc_s;
        logic [2:0]       uc_s;
        logic             rq_lvl;
        logic             rd_lvl;
        logic             lc_lvl;
        logic             uc_lvl;
        logic [DW-1:0]    d0;
        logic [DW-1:0]    d1;
        logic [DW-1:0]    d2;
        logic [CNT_W-1:0] cnt;
        logic [WCNT_W-1:0] wcnt;
        logic [1:0]       ph;
        logic             ready_o;
        logic             ready_oe;
        logic             complete;
        logic             word_valid;
        logic [DW-1:0]    word_data;
        logic             user_clk_en;
        logic             user_mode;
    } pcls_dev_t;

    localparam pcls_dev_t DEV_RESET = '{
        st:          S_HOLD,
        rq_s:        3'h0,
        rd_s:        3'h0,
        lc_s:        3'h0,
        uc_s:        3'h0,
        rq_lvl:      1'b0,
        rd_lvl:      1'b0,
        lc_lvl:      1'b0,
        uc_lvl:      1'b0,
        d0:          16'h0000,
        d1:          16'h0000,
        d2:          16'h0000,
        cnt:         18'h00000,
        wcnt:        24'h000000,
        ph:          2'h0,
        ready_o:     1'b0,
        ready_oe:    1'b1,
        complete:    1'b0,
        word_valid:  1'b0,
        word_data:   16'h0000,
        user_clk_en: 1'b0,
        user_mode:   1'b0
    };

    pcls_dev_t r;
    pcls_dev_t next_r;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic       lc_rise;
        logic       uc_rise;
        logic [2:0] ratio;
        lc_rise = 1'b0;
        uc_rise = 1'b0;
        ratio   = pcls_ratio(bus16, compress, encrypt);
        next_r  = r;
        next_r.word_valid = 1'b0;

        // Pins settle over three flops; a change counts once two agree
        next_r.rq_s = {r.rq_s[1:0], link.config_request_n};
        next_r.rd_s = {r.rd_s[1:0], link.config_ready_n};
        next_r.lc_s = {r.lc_s[1:0], link.load_clock};
        next_r.uc_s = {r.uc_s[1:0], user_init_clock};
        if (r.rq_s[1] == r.rq_s[2])
            next_r.rq_lvl = r.rq_s[2];
        if (r.rd_s[1] == r.rd_s[2])
            next_r.rd_lvl = r.rd_s[2];
        if (r.lc_s[1] == r.lc_s[2]) begin
            next_r.lc_lvl = r.lc_s[2];
            lc_rise = r.lc_s[2] && !r.lc_lvl;
        end
        if (r.uc_s[1] == r.uc_s[2]) begin
            next_r.uc_lvl = r.uc_s[2];
            uc_rise = r.uc_s[2] && !r.uc_lvl;
        end
        // Data rides the same depth so it lines up with the clock edge
        next_r.d0 = link.data;
        next_r.d1 = r.d0;
        next_r.d2 = r.d1;

        case (r.st)
            S_HOLD: begin
                // Minimum low time counts from reset, or from the request falling edge seen outside S_HOLD
                if (r.cnt < CNT_W'(STATUS_MIN_CYC))
                    next_r.cnt = r.cnt + 18'h00001;
                if (r.rq_lvl && r.cnt >= CNT_W'(STATUS_MIN_CYC)) begin
                    next_r.ready_oe = 1'b0;
                    next_r.st       = S_RELEASE;
                end
            end
            S_RELEASE: begin
                // Waits out anyone still holding the wire low
                if (r.rd_lvl) begin
                    next_r.st   = S_LOAD;
                    next_r.wcnt = '0;
                    next_r.ph   = 2'h0;
                end
            end
            S_LOAD: begin
                if (lc_rise) begin
                    if (r.ph == 2'h0) begin
                        next_r.word_data  = bus16 ? r.d2 : {8'h00, r.d2[7:0]};
                        next_r.word_valid = 1'b1;
                        next_r.wcnt       = r.wcnt + 24'h000001;
                        next_r.ph         = 2'(ratio - 3'h1);
                    end else begin
                        next_r.ph = r.ph - 2'h1;
                    end
                    // Completion waits for the trailing edges of the last word
                    if (next_r.wcnt == total_words && next_r.ph == 2'h0) begin
                        next_r.complete = 1'b1;
                        next_r.cnt      = '0;
                        next_r.st       = use_user_clk ? S_CU_WAIT : S_INIT_OSC;
                    end
                end
            end
            S_CU_WAIT: begin
                next_r.cnt = r.cnt + 18'h00001;
                if (next_r.cnt >= CNT_W'(CD2CU_CYC)) begin
                    next_r.user_clk_en = 1'b1;
                    next_r.cnt         = '0;
                    next_r.st          = S_INIT_USER;
                end
            end
            S_INIT_USER: begin
                if (uc_rise) begin
                    next_r.cnt = r.cnt + 18'h00001;
                    if (next_r.cnt >= CNT_W'(INIT_USER_CYC)) begin
                        next_r.user_mode = 1'b1;
                        next_r.st        = S_USER;
                    end
                end
            end
            S_INIT_OSC: begin
                // clk_sys stands in for the internal oscillator
                next_r.cnt = r.cnt + 18'h00001;
                if (next_r.cnt >= CNT_W'(INIT_OSC_CYC)) begin
                    next_r.user_mode = 1'b1;
                    next_r.st        = S_USER;
                end
            end
            S_USER: begin
                next_r.st = S_USER;
            end
            default: begin
                next_r.st = S_HOLD;
            end
        endcase

        // A low request wins over everything else
        if (!r.rq_lvl) begin
            next_r.st          = S_HOLD;
            next_r.ready_oe    = 1'b1;
            next_r.complete    = 1'b0;
            next_r.user_clk_en = 1'b0;
            next_r.user_mode   = 1'b0;
            next_r.word_valid  = 1'b0;
            if (r.st != S_HOLD)
                next_r.cnt = '0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            r <= DEV_RESET;
        else
            r <= next_r;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.dev_ready_o   = r.ready_o;
    assign link.dev_ready_oe  = r.ready_oe;
    assign link.load_complete = r.complete;
    assign word_valid         = r.word_valid;
    assign word_data          = r.word_data;
    assign user_clk_en        = r.user_clk_en;
    assign user_mode          = r.user_mode;

endmodule : pcls_device

// ==== verilog/pcls_host.sv ====
/*
 * Host end: requests, waits for ready, clocks words out.
 * Assumes words come from clk_sys logic with valid/ready.
 */
module pcls_host
    import pcls_pkg::*;
#(
    parameter int unsigned HALF_CYC    = 2,
    parameter bit          MONITOR_RDY = 1'b1,
    parameter int unsigned CF2CK_CYC   = CF2CK_CYC_DEF
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    // Link to the device
    pcls_link_if.host          link,
    // Control
    input  wire logic          start,
    input  wire logic          bus16,
    input  wire logic          compress,
    input  wire logic          encrypt,
    // Word source
    input  wire logic [DW-1:0] in_data,
    input  wire logic          in_valid,
    input  wire logic          in_last,
    output logic               in_ready,
    // Status
    output logic               busy,
    output logic               done,
    output logic               error
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    // Two cycles per phase so the far end's filter sees every level
    if (HALF_CYC < 2 || HALF_CYC < LCLK_HALF_MIN_CYC || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC out of range");
    end
    if (CF2CK_CYC < 1 || CF2CK_CYC >= (1 << CNT_W)) begin : g_bad_cf2ck
        $error("CF2CK_CYC out of range");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [2:0] {H_IDLE, H_REQ, H_WAIT_RDY, H_GAP, H_STREAM, H_WAIT_DONE} pcls_host_st_t;

    typedef struct packed {
        pcls_host_st_t    st;
        logic [2:0]       rd_s;
        logic [2:0]       cd_s;
        logic             rd_lvl;
        logic             cd_lvl;
        logic [CNT_W-1:0] cnt;
        logic [7:0]       hc;
        logic             req_n;
        logic             lclk;
        logic [DW-1:0]    data;
        logic             have;
        logic             last;
        logic [1:0]       ph;
        logic             take;
        logic             busy;
        logic             done;
        logic             error;
    } pcls_host_t;

    pcls_host_t r;
    pcls_host_t next_r;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic       tick;
        logic [2:0] ratio;
        tick   = 1'b0;
        ratio  = pcls_ratio(bus16, compress, encrypt);
        next_r = r;
        next_r.take = 1'b0;
        next_r.rd_s = {r.rd_s[1:0], link.config_ready_n};
        next_r.cd_s = {r.cd_s[1:0], link.load_complete};
        if (r.rd_s[1] == r.rd_s[2])
            next_r.rd_lvl = r.rd_s[2];
        if (r.cd_s[1] == r.cd_s[2])
            next_r.cd_lvl = r.cd_s[2];

        case (r.st)
            H_IDLE: begin
                if (start) begin
                    next_r = '{st: H_REQ, rd_s: next_r.rd_s, cd_s: next_r.cd_s, rd_lvl: next_r.rd_lvl,
                               cd_lvl: next_r.cd_lvl, busy: 1'b1, default: '0};
                end
            end
            H_REQ: begin
                next_r.cnt = r.cnt + 18'h00001;
                if (next_r.cnt >= CNT_W'(CFG_CYC)) begin
                    next_r.req_n = 1'b1;
                    next_r.cnt   = '0;
                    next_r.st    = H_WAIT_RDY;
                end
            end
            H_WAIT_RDY: begin
                next_r.cnt = r.cnt + 18'h00001;
                if (MONITOR_RDY ? r.rd_lvl : (next_r.cnt >= CNT_W'(CF2CK_CYC))) begin
                    next_r.cnt = '0;
                    next_r.st  = MONITOR_RDY ? H_GAP : H_STREAM;
                end
            end
            H_GAP: begin
                next_r.cnt = r.cnt + 18'h00001;
                if (next_r.cnt >= CNT_W'(ST2CK_CYC))
                    next_r.st = H_STREAM;
            end
            H_STREAM: begin
                // Divider ticks every HALF_CYC cycles; a load clock phase lasts one tick, the low phase before a new word at least two
                next_r.hc = r.hc + 8'h01;
                if (next_r.hc >= 8'(HALF_CYC)) begin
                    next_r.hc = 8'h00;
                    tick      = 1'b1;
                end
                if (tick) begin
                    if (r.lclk) begin
                        next_r.lclk = 1'b0;
                        if (r.ph != 2'h0)
                            next_r.ph = r.ph - 2'h1;
                        else
                            next_r.have = 1'b0;
                    end else if (r.have) begin
                        next_r.lclk = 1'b1;
                    end else if (r.last) begin
                        next_r.st = H_WAIT_DONE;
                    end else if (in_valid && !r.take) begin
                        next_r.data = bus16 ? in_data : {8'h00, in_data[7:0]};
                        next_r.take = 1'b1;
                        next_r.have = 1'b1;
                        next_r.last = in_last;
                        next_r.ph   = 2'(ratio - 3'h1);
                    end
                end
            end
            H_WAIT_DONE: begin
                if (r.cd_lvl) begin
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.st   = H_IDLE;
                end
            end
            default: begin
                next_r.st = H_IDLE;
            end
        endcase

        // Ready/error low mid-load means the device gave up
        if ((r.st == H_STREAM || r.st == H_WAIT_DONE) && !r.rd_lvl) begin
            next_r.error = 1'b1;
            next_r.busy  = 1'b0;
            next_r.lclk  = 1'b0;
            next_r.st    = H_IDLE;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            r <= '{st: H_IDLE, req_n: 1'b1, rd_s: 3'h7, rd_lvl: 1'b1, default: '0};
        else
            r <= next_r;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.config_request_n = r.req_n;
    assign link.load_clock       = r.lclk;
    assign link.data             = r.data;
    assign in_ready              = r.take;
    assign busy                  = r.busy;
    assign done                  = r.done;
    assign error                 = r.error;

endmodule : pcls_host

// ==== sim/pcls_checker.sv ====
/*
 * Assertions on the load link.
 * Assumes one clk_sys domain.
 */
module pcls_checker
    import pcls_pkg::*;
#(
    parameter int unsigned STATUS_MIN = 50,
    parameter int unsigned HALF       = 2
) (
    // Clock and reset
    input wire logic          clk_sys,
    input wire logic          rst_b,
    // Link
    input wire logic          config_request_n,
    input wire logic          dev_ready_o,
    input wire logic          dev_ready_oe,
    input wire logic          ext_ready_hold,
    input wire logic          config_ready_n,
    input wire logic          load_complete,
    input wire logic          load_clock,
    input wire logic [DW-1:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Run lengths
    int unsigned req_lo;
    int unsigned rdy_lo;
    int unsigned rdy_hi;
    int unsigned phase;
    logic        lclk_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            req_lo <= 0;
            rdy_lo <= 0;
            rdy_hi <= 0;
            phase  <= HALF;
            lclk_q <= 1'h0;
        end else begin
            req_lo <= config_request_n ? 0 : req_lo + 1;
            rdy_lo <= config_ready_n ? 0 : rdy_lo + 1;
            rdy_hi <= config_ready_n ? rdy_hi + 1 : 0;
            phase  <= (load_clock != lclk_q) ? 1 : phase + 1;
            lclk_q <= load_clock;
        end
    end

    property p_cd_low; $fell(config_request_n) |-> ##[0:60] !load_complete; endproperty
    a_cd_low: assert property (p_cd_low) else $error("complete not dropped");
    property p_rdy_low; $fell(config_request_n) |-> ##[0:60] (dev_ready_oe && !dev_ready_o); endproperty
    a_rdy_low: assert property (p_rdy_low) else $error("ready not pulled low");
    property p_req_len; $rose(config_request_n) |-> req_lo >= CFG_CYC; endproperty
    a_req_len: assert property (p_req_len) else $error("request pulse short");
    // Release after an outside hold is untimed
    property p_rdy_len; $rose(config_ready_n) && !$past(ext_ready_hold) |-> rdy_lo + 8 >= STATUS_MIN; endproperty
    a_rdy_len: assert property (p_rdy_len) else $error("ready low too short");
    property p_rdy_rel; $rose(config_request_n) |-> ##[1:16] (config_ready_n || ext_ready_hold); endproperty
    a_rdy_rel: assert property (p_rdy_rel) else $error("ready not released");
    property p_first; $rose(load_clock) && config_ready_n |-> rdy_hi >= ST2CK_CYC; endproperty
    a_first: assert property (p_first) else $error("clock edge too early");
    property p_phase; (load_clock != lclk_q) |-> phase >= HALF; endproperty
    a_phase: assert property (p_phase) else $error("clock phase short");
    property p_hold; $rose(load_clock) |-> $stable(data) ##1 $stable(data); endproperty
    a_hold: assert property (p_hold) else $error("data moved at edge");
endmodule : pcls_checker

// ==== sim/pcls_tb.sv ====
/*
 * Bench: both ends on one link, a table of loads and a ready hold.
 * Assumes shortened counts set at the instances.
 */
module pcls_tb import pcls_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
`define STEP @(posedge clk_sys) #1
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
    logic              clk_sys = 1'h0, rst_b = 1'h0, start = 1'h0, user_init_clock = 1'h0;
    logic              bus16 = 1'h0, compress = 1'h0, encrypt = 1'h0, use_user_clk = 1'h0;
    logic              in_valid = 1'h0, in_last = 1'h0, in_ready, busy, done, error;
    logic              word_valid, user_clk_en, user_mode;
    logic [DW-1:0]     in_data = 16'h0, word_data, w, exp_q[$];
    logic [WCNT_W-1:0] total_words = 24'h1;
    logic [3:0]        modes[6] = '{4'h8, 4'ha, 4'hc, 4'h5, 4'h2, 4'he};
    int                num_errors = 0, checks = 0, edges = 0, got = 0, cd_cnt = 0, um_at = -1, ce_at = -1;
    pcls_link_if link ();
    always #5 clk_sys = ~clk_sys;
    always #80 user_init_clock = ~user_init_clock;
    always @(posedge link.load_clock) edges++;
    always @(posedge clk_sys) begin
        if (user_clk_en === 1'h1 && ce_at < 0) ce_at = cd_cnt;
        if (user_mode === 1'h1 && um_at < 0) um_at = cd_cnt;
        cd_cnt = (link.load_complete === 1'h1) ? cd_cnt + 1 : 0;
        if (word_valid === 1'h1) begin
            got++;
            w = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
            `CHK("word", w, word_data)
        end
    end
    pcls_device #(.STATUS_MIN_CYC(50), .INIT_OSC_CYC(20), .INIT_USER_CYC(10)) pcls_device_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .link(link), .bus16(bus16), .compress(compress),
        .encrypt(encrypt), .use_user_clk(use_user_clk), .total_words(total_words),
        .user_init_clock(user_init_clock), .word_valid(word_valid), .word_data(word_data),
        .user_clk_en(user_clk_en), .user_mode(user_mode));
    pcls_host #(.CF2CK_CYC(300)) pcls_host_inst (.clk_sys(clk_sys), .rst_b(rst_b), .link(link),
        .start(start), .bus16(bus16), .compress(compress), .encrypt(encrypt), .in_data(in_data),
        .in_valid(in_valid), .in_last(in_last), .in_ready(in_ready), .busy(busy), .done(done), .error(error));
    pcls_checker #(.STATUS_MIN(50)) pcls_checker_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .config_request_n(link.config_request_n), .dev_ready_o(link.dev_ready_o),
        .dev_ready_oe(link.dev_ready_oe), .ext_ready_hold(link.ext_ready_hold),
        .config_ready_n(link.config_ready_n), .load_complete(link.load_complete),
        .load_clock(link.load_clock), .data(link.data));

    // One load; m is {width 16, compression, encryption, user clock}
    task automatic load(input logic [3:0] m, input int n, input int hold);
        int r;
        int k;
        r = m[2] ? (m[3] ? 4 : 2) : ((m[1] && m[3]) ? 2 : 1);
        {bus16, compress, encrypt, use_user_clk} = m;
        total_words = WCNT_W'(n);
        exp_q.delete();
        start = 1'h1;
        `STEP;
        start = 1'h0;
        k = 0;
        while (link.config_request_n !== 1'h0 && k++ < 100) `STEP;
        repeat (60) `STEP;
        `CHK("complete", 1'h0, link.load_complete)
        `CHK("ready", 1'h0, link.config_ready_n)
        `CHK("busy", 1'h1, busy)
        `CHK("umode", 1'h0, user_mode)
        edges = 0;
        got = 0;
        um_at = -1;
        ce_at = -1;
        for (int i = 0; i < n; i++) begin
            in_data = 16'ha5c3 + 16'(i);
            in_valid = 1'h1;
            in_last = (i == n - 1);
            if (i == hold) begin
                link.ext_ready_hold = 1'h1;
                break;
            end
            k = 0;
            do `STEP; while (in_ready !== 1'h1 && ++k < 3000);
            exp_q.push_back(m[3] ? in_data : in_data & 16'h00ff);
        end
        in_valid = 1'h0;
        in_last = 1'h0;
        if (hold >= 0) begin
            repeat (20) `STEP;
            link.ext_ready_hold = 1'h0;
            `CHK("error", 1'h1, error)
            `CHK("done", 1'h0, done)
        end else begin
            k = 0;
            while (user_mode !== 1'h1 && k++ < 3000) `STEP;
            `STEP;
            `CHK("done", 1'h1, done)
            `CHK("words", n, got)
            `CHK("edges", r * n, edges)
            if (m[0]) begin
                `CHK("clk_en", 1'h1, ce_at >= CD2CU_CYC)
                `CHK("umode_t", 1'h1, um_at >= CD2CU_CYC + 9 * 16)
            end else begin
                `CHK("umode_t", 1'h1, um_at >= 19 && um_at <= 26)
                `CHK("clk_en", 1'h0, user_clk_en)
            end
        end
        $display("load %0h words %0d over", m, n);
    endtask : load

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    initial begin
        link.ext_ready_hold = 1'h0;
        repeat (2) @(posedge clk_sys);
        #1 rst_b = 1'h1;
        foreach (modes[j]) load(modes[j], j + 2, (j == 5) ? 1 : -1);
        load(4'h8, 1, -1);
        close_out();
    end
    // Loads need well under this
    initial begin
        #400000;
        num_errors++;
        close_out();
    end
endmodule : pcls_tb
